// ### verilog/eeac_pkg.sv
/*
   Constants, types and helper functions shared by the byte-wide
   non-volatile data memory controller and its two leaf modules.
   Assumes a single 10 MHz system clock and an 8-bit register port.
*/
`default_nettype none

package eeac_pkg;

   localparam int EEAC_DATA_W          = 8;
   localparam int EEAC_ADDR_W          = 6;
   localparam int EEAC_MEM_DEPTH       = 64;

   localparam logic [7:0] EEAC_CTRL_BANK = 8'h01;
   localparam logic [7:0] EEAC_CTRL_PTR  = 8'h40;

   localparam int EEAC_WRITE_PERMIT_BIT = 3;
   localparam int EEAC_WRITE_GO_BIT     = 2;
   localparam int EEAC_READ_PERMIT_BIT  = 1;
   localparam int EEAC_READ_GO_BIT      = 0;

   localparam logic [7:0] EEAC_BANK_RESET = 8'h00;
   localparam logic [7:0] EEAC_PTR_RESET  = 8'h00;
   localparam logic [7:0] EEAC_DATA_RESET = 8'h00;
   localparam logic [5:0] EEAC_ADDR_RESET = 6'h00;

   localparam int EEAC_CLOCK_NS      = 100;
   localparam int EEAC_TIMER_TICK_NS = 1000;
   localparam int EEAC_TICK_CYCLES   =
      (EEAC_TIMER_TICK_NS + EEAC_CLOCK_NS - 1) / EEAC_CLOCK_NS;
   localparam int EEAC_WRITE_TIME_US = 2000;
   localparam int EEAC_WRITE_TICKS   = (EEAC_WRITE_TIME_US * 1000) / EEAC_TIMER_TICK_NS;
   localparam int EEAC_READ_CYCLES   = 2;
   localparam int EEAC_TIMER_W       = 16;

   typedef enum logic [2:0] {
      SEL_ADDR,
      SEL_DATA,
      SEL_BANK,
      SEL_PTR,
      SEL_IND
   } eeac_sel_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      eeac_sel_t  sel;
      logic [7:0] wdata;
   } eeac_sfr_req_t;

   function automatic logic eeac_hits_ctrl(input logic [7:0] bank, input logic [7:0] ptr);
      eeac_hits_ctrl = (bank == EEAC_CTRL_BANK) && (ptr == EEAC_CTRL_PTR);
   endfunction

   function automatic logic [7:0] eeac_pack_ctrl(input logic wp, input logic wg,
                                                 input logic rp, input logic rg);
      logic [7:0] v;
      v = 8'h00;
      v[EEAC_WRITE_PERMIT_BIT] = wp;
      v[EEAC_WRITE_GO_BIT]     = wg;
      v[EEAC_READ_PERMIT_BIT]  = rp;
      v[EEAC_READ_GO_BIT]      = rg;
      eeac_pack_ctrl = v;
   endfunction

endpackage

`default_nettype wire

// ### verilog/eeac_store.sv
/*
   The 64-byte storage array with a synchronous write port and a
   combinational read port. Assumes the controller presents stable
   addresses; the array has no reset because its content is retained.
*/
`timescale 1ns/1ns
`default_nettype none

module eeac_store
   import eeac_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   write_en,
   input  wire logic [EEAC_ADDR_W-1:0] write_addr,
   input  wire logic [EEAC_DATA_W-1:0] write_data,
   input  wire logic [EEAC_ADDR_W-1:0] read_addr,
   output logic      [EEAC_DATA_W-1:0] read_data
);

   logic [EEAC_DATA_W-1:0] cells [EEAC_MEM_DEPTH];

   always_ff @(posedge clock) begin
      if (write_en) begin
         cells[write_addr] <= write_data;
      end
   end

   assign read_data = cells[read_addr];

endmodule // eeac_store

`default_nettype wire

// ### verilog/eeac_wr_timer.sv
/*
   Self-timed write cycle timer. A free-running prescaler that never
   restarts gives ticks whose phase is unrelated to the start request,
   so a cycle's length in system clocks varies by up to one tick.
   Assumes start is a one-cycle pulse given only while not busy.
*/
`timescale 1ns/1ns
`default_nettype none

module eeac_wr_timer
   import eeac_pkg::*;
#(
   parameter int TICKS = EEAC_WRITE_TICKS
)
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      done,
   output logic      busy
);

   localparam logic [EEAC_TIMER_W-1:0] TICK_LAST  = EEAC_TIMER_W'(EEAC_TICK_CYCLES - 1);
   localparam logic [EEAC_TIMER_W-1:0] TICKS_LOAD = EEAC_TIMER_W'(TICKS);

   logic [EEAC_TIMER_W-1:0] prescale;
   logic [EEAC_TIMER_W-1:0] remaining;

   wire logic tick     = (prescale == TICK_LAST);
   wire logic finish   = busy && tick && (remaining <= EEAC_TIMER_W'(1));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prescale <= '0;
      end else begin
         prescale <= tick ? '0 : prescale + EEAC_TIMER_W'(1);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         remaining <= '0;
         busy      <= 1'b0;
         done      <= 1'b0;
      end else begin
         done <= finish;
         if (start) begin
            remaining <= TICKS_LOAD;
            busy      <= 1'b1;
         end else if (finish) begin
            remaining <= '0;
            busy      <= 1'b0;
         end else if (busy && tick) begin
            remaining <= remaining - EEAC_TIMER_W'(1);
         end
      end
   end

endmodule // eeac_wr_timer

`default_nettype wire

// ### verilog/eeac_ctrl.sv
/*
   Byte-wide non-volatile data memory controller: address, data and
   control registers, bank and indirect pointer decoding, the write and
   read cycles and the write-complete interrupt flags.
   Assumes the processor core issues one register access per cycle on
   the sfr port and pulses irq_ack when it takes the vector.

*/
`timescale 1ns/1ns
`default_nettype none

module eeac_ctrl
   import eeac_pkg::*;
#(
   parameter int WRITE_TICKS = EEAC_WRITE_TICKS
)
(
   input  wire logic          clock,
   input  wire logic          rst_b,
   input  wire eeac_sfr_req_t sfr,
   input  wire logic          global_irq_enable,
   input  wire logic          nvm_irq_enable,
   input  wire logic          mf_irq_enable,
   input  wire logic          stack_full,
   input  wire logic          irq_ack,
   input  wire logic          nvm_flag_clear,
   output logic [7:0]         sfr_rdata,
   output logic               nvm_irq_flag,
   output logic               mf_irq_flag,
   output logic               irq_vector,
   output logic               cycle_busy
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WRITE,
      ST_READ
   } eeac_state_t;

   logic                   rst_meta;
   logic                   rst_n;
   eeac_state_t            state;
   eeac_state_t            next_state;
   logic [EEAC_ADDR_W-1:0] nvm_address_reg;
   logic [EEAC_DATA_W-1:0] nvm_data_reg;
   logic [7:0]             bank_select;
   logic [7:0]             indirect_pointer_one;
   logic                   nvm_write_permit;
   logic                   nvm_write_go;
   logic                   nvm_read_permit;
   logic                   nvm_read_go;
   logic [EEAC_ADDR_W-1:0] lat_addr;
   logic [EEAC_DATA_W-1:0] lat_data;
   logic [1:0]             read_count;
   logic                   wr_done;
   logic                   timer_busy;
   logic [EEAC_DATA_W-1:0] mem_rdata;

   // The core is released from reset only after two clean edges.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Register decode. The control register answers only through the
   // indirect port with the pointer and the bank at their fixed values.
   wire logic ctrl_hit  = eeac_hits_ctrl(bank_select, indirect_pointer_one);
   wire logic ctrl_wr   = sfr.wr && (sfr.sel == SEL_IND) && ctrl_hit;
   wire logic addr_wr   = sfr.wr && (sfr.sel == SEL_ADDR) && (state != ST_READ);
   wire logic data_wr   = sfr.wr && (sfr.sel == SEL_DATA) && (state != ST_READ);
   wire logic bank_wr   = sfr.wr && (sfr.sel == SEL_BANK);
   wire logic ptr_wr    = sfr.wr && (sfr.sel == SEL_PTR);
   wire logic idle      = (state == ST_IDLE);

   wire logic go_write_bit  = sfr.wdata[EEAC_WRITE_GO_BIT];
   wire logic go_read_bit   = sfr.wdata[EEAC_READ_GO_BIT];
   wire logic wr_start = ctrl_wr && go_write_bit && nvm_write_permit && idle;
   // A simultaneous request for both cycles is served as a write only.
   wire logic rd_start = ctrl_wr && go_read_bit && nvm_read_permit && idle
                         && !wr_start;
   wire logic rd_done  = (state == ST_READ) && (read_count == 2'h1);

   wire logic [7:0] ctrl_value = eeac_pack_ctrl(nvm_write_permit, nvm_write_go,
                                                nvm_read_permit, nvm_read_go);
   wire logic [7:0] ind_value  = ctrl_hit ? ctrl_value : 8'h00;
   wire logic [7:0] rd_mux =
      (sfr.sel == SEL_ADDR) ? {2'h0, nvm_address_reg} :
      (sfr.sel == SEL_DATA) ? nvm_data_reg :
      (sfr.sel == SEL_BANK) ? bank_select :
      (sfr.sel == SEL_PTR)  ? indirect_pointer_one :
      (sfr.sel == SEL_IND)  ? ind_value : 8'h00;

   wire logic next_vector = global_irq_enable && nvm_irq_enable && mf_irq_enable
                            && mf_irq_flag && !stack_full && !irq_ack;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (wr_start) begin
               next_state = ST_WRITE;
            end else if (rd_start) begin
               next_state = ST_READ;
            end
         end
         ST_WRITE: begin
            if (wr_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_READ: begin
            if (rd_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state      <= ST_IDLE;
         cycle_busy <= 1'b0;
         read_count <= 2'h0;
      end else begin
         state      <= next_state;
         cycle_busy <= (next_state != ST_IDLE);
         read_count <= rd_start ? 2'(EEAC_READ_CYCLES) :
                       (read_count != 2'h0) ? read_count - 2'h1 : 2'h0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bank_select          <= EEAC_BANK_RESET;
         indirect_pointer_one <= EEAC_PTR_RESET;
         nvm_address_reg      <= EEAC_ADDR_RESET;
      end else begin
         if (bank_wr) begin
            bank_select <= sfr.wdata;
         end
         if (ptr_wr) begin
            indirect_pointer_one <= sfr.wdata;
         end
         if (addr_wr) begin
            nvm_address_reg <= sfr.wdata[EEAC_ADDR_W-1:0];
         end
      end
   end

   // The fetched byte stays until the next read result or software write.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nvm_data_reg <= EEAC_DATA_RESET;
      end else if (rd_done) begin
         nvm_data_reg <= mem_rdata;
      end else if (data_wr) begin
         nvm_data_reg <= sfr.wdata;
      end
   end

   // The byte and location are frozen at launch so that software may
   // touch the registers while the slow cycle runs.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lat_addr <= EEAC_ADDR_RESET;
         lat_data <= EEAC_DATA_RESET;
      end else if (wr_start) begin
         lat_addr <= nvm_address_reg;
         lat_data <= nvm_data_reg;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nvm_write_permit <= 1'b0;
         nvm_read_permit  <= 1'b0;
      end else if (ctrl_wr) begin
         nvm_write_permit <= sfr.wdata[EEAC_WRITE_PERMIT_BIT];
         nvm_read_permit  <= sfr.wdata[EEAC_READ_PERMIT_BIT];
      end
   end

   // Software cannot clear a go bit: only cycle completion does.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nvm_write_go <= 1'b0;
         nvm_read_go  <= 1'b0;
      end else begin
         nvm_write_go <= wr_done ? 1'b0 : (wr_start ? 1'b1 : nvm_write_go);
         nvm_read_go  <= rd_done ? 1'b0 : (rd_start ? 1'b1 : nvm_read_go);
      end
   end

   // A completion arriving with a clear keeps the flag set.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nvm_irq_flag <= 1'b0;
         mf_irq_flag  <= 1'b0;
         irq_vector   <= 1'b0;
         sfr_rdata    <= 8'h00;
      end else begin
         nvm_irq_flag <= wr_done ? 1'b1 : (nvm_flag_clear ? 1'b0 : nvm_irq_flag);
         mf_irq_flag  <= wr_done ? 1'b1 : (irq_ack ? 1'b0 : mf_irq_flag);
         irq_vector   <= next_vector;
         sfr_rdata    <= sfr.rd ? rd_mux : sfr_rdata;
      end
   end

   eeac_wr_timer #(
      .TICKS (WRITE_TICKS)
   ) u_timer (
      .clock (clock),
      .rst_n (rst_n),
      .start (wr_start),
      .done  (wr_done),
      .busy  (timer_busy)
   );

   eeac_store u_store (
      .clock      (clock),
      .write_en   (wr_done),
      .write_addr (lat_addr),
      .write_data (lat_data),
      .read_addr  (nvm_address_reg),
      .read_data  (mem_rdata)
   );

   property p_write_needs_permit;
      @(posedge clock) disable iff (!rst_n)
      (idle && ctrl_wr && go_write_bit && !nvm_write_permit) |=> !nvm_write_go;
   endproperty
   a_write_needs_permit: assert property (p_write_needs_permit)
      else $error("write started without write permit");

   property p_write_go_clears;
      @(posedge clock) disable iff (!rst_n)
      wr_done |=> (!nvm_write_go && state == ST_IDLE);
   endproperty
   a_write_go_clears: assert property (p_write_go_clears)
      else $error("write go not cleared at write end");

   property p_reset_protect;
      @(posedge clock) disable iff (!rst_n)
      $rose(rst_n) |-> (!nvm_write_permit && bank_select == 8'h00 && !ctrl_hit);
   endproperty
   a_reset_protect: assert property (p_reset_protect)
      else $error("write protection not in place after reset");

   property p_done_sets_flags;
      @(posedge clock) disable iff (!rst_n)
      wr_done |=> (nvm_irq_flag && mf_irq_flag);
   endproperty
   a_done_sets_flags: assert property (p_done_sets_flags)
      else $error("write end did not set both flags");

   property p_vector_gate;
      @(posedge clock) disable iff (!rst_n)
      irq_vector |-> $past(global_irq_enable && nvm_irq_enable && mf_irq_enable
                           && mf_irq_flag && !stack_full);
   endproperty
   a_vector_gate: assert property (p_vector_gate)
      else $error("vector raised without all enables");

   property p_service_clears_parent;
      @(posedge clock) disable iff (!rst_n)
      (irq_ack && !wr_done && !nvm_flag_clear && nvm_irq_flag)
         |=> (!mf_irq_flag && nvm_irq_flag);
   endproperty
   a_service_clears_parent: assert property (p_service_clears_parent)
      else $error("service cleared the wrong flag");

   property p_read_needs_permit;
      @(posedge clock) disable iff (!rst_n)
      (idle && ctrl_wr && go_read_bit && !go_write_bit && !nvm_read_permit)
         |=> (!nvm_read_go && state == ST_IDLE);
   endproperty
   a_read_needs_permit: assert property (p_read_needs_permit)
      else $error("read started without read permit");

   property p_read_result;
      @(posedge clock) disable iff (!rst_n)
      $rose(nvm_read_go) |-> ##1 nvm_read_go
         ##1 (!nvm_read_go && nvm_data_reg == $past(mem_rdata));
   endproperty
   a_read_result: assert property (p_read_result)
      else $error("read cycle did not end with data loaded");

   property p_busy_holds_go;
      @(posedge clock) disable iff (!rst_n)
      (nvm_write_go && !wr_done) |=> (nvm_write_go && state == ST_WRITE && !nvm_read_go);
   endproperty
   a_busy_holds_go: assert property (p_busy_holds_go)
      else $error("write cycle disturbed while running");

   property p_timer_follows_go;
      @(posedge clock) disable iff (!rst_n)
      wr_start |=> (timer_busy && nvm_write_go) ##1 !wr_done;
   endproperty
   a_timer_follows_go: assert property (p_timer_follows_go)
      else $error("write timer not running after launch");

endmodule // eeac_ctrl

`default_nettype wire

// ### testbench/eeac_ctrl_test.sv
/*
   Self-checking testbench for eeac_ctrl: reset state, write protection,
   a full self-timed write, the interrupt flags and vector, and reads.
   Assumes the design's own assertions sit in its files; the write timer
   is shortened to three ticks so a write lasts a few dozen clocks.
*/
`timescale 1ns/1ns
`default_nettype none

module eeac_ctrl_test
   import eeac_pkg::*;
;
   localparam int TICKS   = 3;
   localparam int MIN_CYC = 10 * (TICKS - 1) + 1;
   localparam int MAX_CYC = 10 * TICKS + 1;

   logic          clock = 1'b0;
   logic          rst_b;
   eeac_sfr_req_t sfr;
   logic          global_irq_enable;
   logic          nvm_irq_enable;
   logic          mf_irq_enable;
   logic          stack_full;
   logic          irq_ack;
   logic          nvm_flag_clear;
   logic [7:0]    sfr_rdata;
   logic          nvm_irq_flag;
   logic          mf_irq_flag;
   logic          irq_vector;
   logic          cycle_busy;
   int            num_errors = 0;
   int            checked    = 0;

   eeac_ctrl #(.WRITE_TICKS(TICKS)) i_dut (
      .clock             (clock),
      .rst_b             (rst_b),
      .sfr               (sfr),
      .global_irq_enable (global_irq_enable),
      .nvm_irq_enable    (nvm_irq_enable),
      .mf_irq_enable     (mf_irq_enable),
      .stack_full        (stack_full),
      .irq_ack           (irq_ack),
      .nvm_flag_clear    (nvm_flag_clear),
      .sfr_rdata         (sfr_rdata),
      .nvm_irq_flag      (nvm_irq_flag),
      .mf_irq_flag       (mf_irq_flag),
      .irq_vector        (irq_vector),
      .cycle_busy        (cycle_busy)
   );

   always #50 clock = ~clock;

   task automatic end_sim();
      if (num_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         num_errors++;
      end
   endtask

   // Each access leaves an idle cycle behind it so no strobe is set twice in one step.
   task automatic wr(input eeac_sel_t s, input logic [7:0] d);
      @(negedge clock);
      sfr.wr    = 1'b1;
      sfr.sel   = s;
      sfr.wdata = d;
      @(negedge clock);
      sfr.wr    = 1'b0;
   endtask

   task automatic rd(input eeac_sel_t s, output logic [7:0] v);
      @(negedge clock);
      sfr.rd  = 1'b1;
      sfr.sel = s;
      @(negedge clock);
      sfr.rd  = 1'b0;
      v       = sfr_rdata;
   endtask

   task automatic flags(input string name, input logic [7:0] exp);
      chk(name, {4'h0, nvm_irq_flag, mf_irq_flag, irq_vector, cycle_busy}, exp);
   endtask

   // Polls one go bit until hardware clears it; running out counts as a mismatch.
   task automatic poll(input int b, output int n);
      logic [7:0] v;
      n = 0;
      do begin
         rd(SEL_IND, v);
         n++;
      end while (v[b] !== 1'b0 && n < 200);
      if (v[b] !== 1'b0) begin
         chk("go_clear", {7'h0, v[b]}, 8'h00);
         end_sim();
      end
   endtask

   task automatic t_reset_state();
      logic [7:0] v;
      flags("flags_rst", 8'h00);
      rd(SEL_ADDR, v); chk("addr_rst", v, {2'b00, EEAC_ADDR_RESET});
      rd(SEL_DATA, v); chk("data_rst", v, EEAC_DATA_RESET);
      rd(SEL_BANK, v); chk("bank_rst", v, 8'h00);
      rd(SEL_PTR, v);  chk("ptr_rst", v, EEAC_PTR_RESET);
      wr(SEL_IND, 8'h08);
      rd(SEL_IND, v);  chk("ctrl_bank0", v, 8'h00);
      wr(SEL_BANK, 8'h01);
      wr(SEL_PTR, 8'h40);
      rd(SEL_IND, v);  chk("ctrl_rst", v, 8'h00);
   endtask

   task automatic t_write_guard();
      logic [7:0] v;
      wr(SEL_IND, 8'h04);
      rd(SEL_IND, v); chk("ctrl_no_permit", v, 8'h00);
      flags("busy_no_permit", 8'h00);
   endtask

   task automatic t_write_cycle();
      logic [7:0] v;
      int         n;
      wr(SEL_ADDR, 8'h2A);
      wr(SEL_DATA, 8'hA5);
      global_irq_enable = 1'b0;
      @(negedge clock);
      sfr.wr    = 1'b1;
      sfr.sel   = SEL_IND;
      sfr.wdata = 8'h08;
      @(negedge clock);
      sfr.wdata = 8'h0C;
      @(negedge clock);
      sfr.wr    = 1'b0;
      global_irq_enable = 1'b1;
      chk("busy_write", {7'h0, cycle_busy}, 8'h01);
      wr(SEL_IND, 8'h0E);
      wr(SEL_IND, 8'h0B);
      rd(SEL_IND, v); chk("ctrl_running", v, 8'h0E);
      poll(EEAC_WRITE_GO_BIT, n);
      chk("write_length", {7'h0, (2 * n + 8) >= MIN_CYC}, 8'h01);
      chk("write_max", {7'h0, (2 * n + 4) < MAX_CYC}, 8'h01);
      rd(SEL_IND, v); chk("ctrl_done", v, 8'h0A);
      chk("flags_done", {6'h0, nvm_irq_flag, mf_irq_flag}, 8'h03);
      wr(SEL_IND, 8'h00);
   endtask

   task automatic t_irq();
      logic [3:0] en;
      for (int i = 0; i < 5; i++) begin
         en = 4'hF;
         if (i < 4)
            en[i] = 1'b0;
         @(negedge clock);
         {global_irq_enable, nvm_irq_enable, mf_irq_enable} = en[3:1];
         stack_full = ~en[0];
         repeat (2) @(negedge clock);
         chk("vector", {7'h0, irq_vector}, {7'h0, i == 4});
      end
      irq_ack = 1'b1;
      @(negedge clock);
      irq_ack = 1'b0;
      @(negedge clock);
      flags("after_ack", 8'h08);
      nvm_flag_clear = 1'b1;
      @(negedge clock);
      nvm_flag_clear = 1'b0;
      @(negedge clock);
      flags("after_clear", 8'h00);
   endtask

   task automatic t_read();
      logic [7:0] v;
      int         n;
      wr(SEL_IND, 8'h01);
      rd(SEL_IND, v); chk("ctrl_no_rpermit", v, 8'h00);
      flags("busy_no_rpermit", 8'h00);
      wr(SEL_DATA, 8'h00);
      wr(SEL_IND, 8'h02);
      wr(SEL_IND, 8'h03);
      poll(EEAC_READ_GO_BIT, n);
      rd(SEL_IND, v);  chk("ctrl_read_done", v, 8'h02);
      rd(SEL_DATA, v); chk("read_back", v, 8'hA5);
      rd(SEL_DATA, v); chk("read_hold", v, 8'hA5);
      wr(SEL_ADDR, 8'hFF);
      rd(SEL_ADDR, v); chk("addr_width", v, 8'h3F);
      wr(SEL_IND, 8'h00);
   endtask

   initial begin
      rst_b             = 1'b0;
      sfr               = '0;
      sfr.sel           = SEL_ADDR;
      global_irq_enable = 1'b0;
      nvm_irq_enable    = 1'b0;
      mf_irq_enable     = 1'b0;
      stack_full        = 1'b0;
      irq_ack           = 1'b0;
      nvm_flag_clear    = 1'b0;
      repeat (8) @(negedge clock);
      rst_b = 1'b1;
      repeat (3) @(negedge clock);
      t_reset_state();
      t_write_guard();
      t_write_cycle();
      t_irq();
      t_read();
      end_sim();
   end

endmodule // eeac_ctrl_test

`default_nettype wire
